// ===== vgast_pkg.sv
package vgast_pkg;

    // horizontal intervals in pixel clocks (640x480 at 60 Hz)
    localparam int PIXEL_CLOCK_MHZ = 25;
    localparam int H_SYNC_CYC      = 96;
    localparam int H_BACK_CYC      = 48;
    localparam int H_DISP_CYC      = 640;
    localparam int H_FRONT_CYC     = 16;
    // vertical intervals in lines
    localparam int V_SYNC_LINES    = 2;
    localparam int V_BACK_LINES    = 33;
    localparam int V_DISP_LINES    = 480;
    localparam int V_FRONT_LINES   = 10;
    localparam int COLOR_W         = 10;
    localparam int CNT_W           = 10;

    localparam logic [CNT_W-1:0] CNT_RESET = 10'h000;

    typedef enum logic [1:0] {
        VGAST_SYNC,
        VGAST_BACK,
        VGAST_DISP,
        VGAST_FRONT
    } vgast_phase_t;

    typedef struct packed {
        logic [COLOR_W-1:0] red;
        logic [COLOR_W-1:0] green;
        logic [COLOR_W-1:0] blue;
    } vgast_rgb_t;

endpackage : vgast_pkg

// ===== vgast_timing.sv
`timescale 1ns/10ps
module vgast_timing (
    // clock and reset (clock is the pixel clock)
    input  wire logic                  CLOCK_IN,
    input  wire logic                  RESETN_IN,
    // pixel source
    input  wire vgast_pkg::vgast_rgb_t PIXEL_IN,
    // raster position and pixel request
    output logic                       PIXEL_REQ_OUT,
    output logic [vgast_pkg::CNT_W-1:0] COLUMN_OUT,
    output logic [vgast_pkg::CNT_W-1:0] ROW_OUT,
    // monitor and dac
    output logic                       HSYNC_N_OUT,
    output logic                       VSYNC_N_OUT,
    output logic                       BLANKING_STROBE_N_OUT,
    output vgast_pkg::vgast_rgb_t      RGB_OUT
);
    import vgast_pkg::*;

    vgast_phase_t      hph_reg, hph_next, vph_reg, vph_next;
    logic [CNT_W-1:0]  hcnt_reg, hcnt_next, vcnt_reg, vcnt_next;
    logic              hsync_n_reg, hsync_n_next;
    logic              vsync_n_reg, vsync_n_next;
    logic              blank_n_reg, blank_n_next;
    logic              req_reg, req_next;
    logic [CNT_W-1:0]  col_reg, col_next, row_reg, row_next;
    vgast_rgb_t        rgb_reg, rgb_next;
    logic              h_last, line_end, v_last, disp_now;

    function automatic logic [CNT_W-1:0] h_len(input vgast_phase_t p);
        unique case (p)
            VGAST_SYNC:  h_len = CNT_W'(H_SYNC_CYC - 1);
            VGAST_BACK:  h_len = CNT_W'(H_BACK_CYC - 1);
            VGAST_DISP:  h_len = CNT_W'(H_DISP_CYC - 1);
            VGAST_FRONT: h_len = CNT_W'(H_FRONT_CYC - 1);
        endcase
    endfunction : h_len

    function automatic logic [CNT_W-1:0] v_len(input vgast_phase_t p);
        unique case (p)
            VGAST_SYNC:  v_len = CNT_W'(V_SYNC_LINES - 1);
            VGAST_BACK:  v_len = CNT_W'(V_BACK_LINES - 1);
            VGAST_DISP:  v_len = CNT_W'(V_DISP_LINES - 1);
            VGAST_FRONT: v_len = CNT_W'(V_FRONT_LINES - 1);
        endcase
    endfunction : v_len

    // phase walk: sync, back porch, display, front porch
    always_comb begin
        h_last    = (hcnt_reg == h_len(hph_reg));
        line_end  = h_last && (hph_reg == VGAST_FRONT);
        v_last    = (vcnt_reg == v_len(vph_reg));
        hph_next  = hph_reg;
        hcnt_next = hcnt_reg + 10'h001;
        vph_next  = vph_reg;
        vcnt_next = vcnt_reg;
        if (h_last) begin
            hcnt_next = CNT_RESET;
            hph_next  = vgast_phase_t'(hph_reg + 2'h1);
        end
        // vertical steps once per row
        if (line_end) begin
            vcnt_next = vcnt_reg + 10'h001;
            if (v_last) begin
                vcnt_next = CNT_RESET;
                vph_next  = vgast_phase_t'(vph_reg + 2'h1);
            end
        end
    end

    // outputs follow the phase one clock later, all registered
    always_comb begin
        disp_now     = (hph_reg == VGAST_DISP) && (vph_reg == VGAST_DISP);
        hsync_n_next = (hph_reg != VGAST_SYNC);
        vsync_n_next = (vph_reg != VGAST_SYNC);
        blank_n_next = disp_now;
        // colour forced off outside the display interval
        rgb_next     = disp_now ? PIXEL_IN : '0;
        req_next     = disp_now;
        col_next     = hcnt_reg;
        row_next     = vcnt_reg;
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RESETN_IN) begin
            hph_reg     <= VGAST_SYNC;
            vph_reg     <= VGAST_SYNC;
            hcnt_reg    <= CNT_RESET;
            vcnt_reg    <= CNT_RESET;
            hsync_n_reg <= 1'b1;
            vsync_n_reg <= 1'b1;
            blank_n_reg <= 1'b0;
            req_reg     <= 1'b0;
            col_reg     <= CNT_RESET;
            row_reg     <= CNT_RESET;
            rgb_reg     <= '0;
        end else begin
            hph_reg     <= hph_next;
            vph_reg     <= vph_next;
            hcnt_reg    <= hcnt_next;
            vcnt_reg    <= vcnt_next;
            hsync_n_reg <= hsync_n_next;
            vsync_n_reg <= vsync_n_next;
            blank_n_reg <= blank_n_next;
            req_reg     <= req_next;
            col_reg     <= col_next;
            row_reg     <= row_next;
            rgb_reg     <= rgb_next;
        end
    end

    assign HSYNC_N_OUT           = hsync_n_reg;
    assign VSYNC_N_OUT           = vsync_n_reg;
    assign BLANKING_STROBE_N_OUT = blank_n_reg;
    assign PIXEL_REQ_OUT         = req_reg;
    assign COLUMN_OUT            = col_reg;
    assign ROW_OUT               = row_reg;
    assign RGB_OUT               = rgb_reg;

    // helpers: length of the current low hsync and vsync runs
    // vsync stays low 1600 clocks, far past what a repetition can count
    localparam int VLOW_W = CNT_W + 1;
    logic [CNT_W-1:0]  hlow_reg, hlow_next;
    logic [VLOW_W-1:0] vlow_reg, vlow_next;

    always_comb begin
        hlow_next = hsync_n_reg ? CNT_RESET : hlow_reg + 10'h001;
        vlow_next = vsync_n_reg ? 11'h000 : vlow_reg + 11'h001;
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RESETN_IN) begin
            hlow_reg <= CNT_RESET;
            vlow_reg <= 11'h000;
        end else begin
            hlow_reg <= hlow_next;
            vlow_reg <= vlow_next;
        end
    end

    sequence s_hsync_fall;
        $fell(hsync_n_reg);
    endsequence

    sequence s_back_dark;
        (rgb_reg == '0) [*8];
    endsequence

    chk_hsync_width: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        $rose(hsync_n_reg) |-> $past(hlow_reg) == CNT_W'(H_SYNC_CYC - 1))
        else $error("hsync pulse width wrong");

    chk_hsync_max: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        !hsync_n_reg |-> hlow_reg < CNT_W'(H_SYNC_CYC))
        else $error("hsync held low too long");

    chk_back_dark: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        $rose(hsync_n_reg) |-> s_back_dark)
        else $error("colour not zero after hsync");

    chk_blank_rgb: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        !blank_n_reg |-> rgb_reg == '0)
        else $error("colour driven while blanked");

    chk_pixel_step: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        req_reg && $past(req_reg) |-> col_reg == $past(col_reg) + 10'h001)
        else $error("pixel column did not step");

    chk_disp_start: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        $rose(req_reg) |-> col_reg == CNT_RESET)
        else $error("row did not start at column zero");

    chk_front_sync: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        $fell(req_reg) |-> ##(H_FRONT_CYC) s_hsync_fall)
        else $error("front porch length wrong");

    chk_vsync_line: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        $changed(vsync_n_reg) |-> $fell(hsync_n_reg))
        else $error("vsync edge not on row boundary");

    chk_vsync_rows: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        $rose(vsync_n_reg) |-> $past(vlow_reg) == VLOW_W'(V_SYNC_LINES
            * (H_SYNC_CYC + H_BACK_CYC + H_DISP_CYC + H_FRONT_CYC) - 1))
        else $error("vsync not two rows long");

    chk_vsync_max: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        !vsync_n_reg |-> vlow_reg < VLOW_W'(V_SYNC_LINES
            * (H_SYNC_CYC + H_BACK_CYC + H_DISP_CYC + H_FRONT_CYC)))
        else $error("vsync held low too long");

    chk_col_range: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        req_reg |-> col_reg < CNT_W'(H_DISP_CYC))
        else $error("pixel column past row end");

    chk_row_range: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        req_reg |-> row_reg < CNT_W'(V_DISP_LINES))
        else $error("pixel row past frame end");

    chk_req_blank: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        req_reg == blank_n_reg)
        else $error("request and blanking strobe disagree");

endmodule : vgast_timing

// ===== vgast_monitor.sv
`timescale 1ns/10ps
module vgast_monitor
    import vgast_pkg::*;
(
    // raster timing and colour from the block
    input  wire logic       clk_in,
    input  wire logic       hsync_n_in,
    input  wire logic       vsync_n_in,
    input  wire logic       blank_n_in,
    input  wire vgast_rgb_t rgb_in,
    // measured widths in pixel clocks, and a count of colour errors while blanked
    output int              hs_low_out,
    output int              hs_period_out,
    output int              vs_low_out,
    output int              rgb_err_out
);
    int   hl = 0;
    int   hp = 0;
    int   vl = 0;
    logic hs_d = 1'b1;
    logic vs_d = 1'b1;

    initial begin
        hs_low_out = 0;
        hs_period_out = 0;
        vs_low_out = 0;
        rgb_err_out = 0;
    end

    // sync and colour taken on one edge, as after the bus split
    // sync pins read straight, only colour goes through the dac
    always @(posedge clk_in) begin
        if (hsync_n_in && !hs_d) hs_low_out = hl;
        hl = hsync_n_in ? 0 : hl + 1;
        hp = hp + 1;
        if (!hsync_n_in && hs_d) begin
            hs_period_out = hp;
            hp = 0;
        end
        if (vsync_n_in && !vs_d) vs_low_out = vl;
        vl = vsync_n_in ? 0 : vl + 1;
        // all three ten-bit channels must be dark while blanked
        if (!blank_n_in && rgb_in !== '0) rgb_err_out++;
        hs_d = hsync_n_in;
        vs_d = vsync_n_in;
    end
endmodule : vgast_monitor

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import vgast_pkg::*;
    logic             clock_in = 1'b0;
    logic             resetn_in = 1'b0;
    logic [29:0]      pix = '0;
    logic [29:0]      last_pix = '0;
    logic             req, hs_n, vs_n, blank_n;
    logic [CNT_W-1:0] col, row;
    vgast_rgb_t       rgb;
    int               hs_low, hs_per, vs_low, rgb_err, n;
    int               n_errors = 0;
    int               check_count = 0;
    int               cycles = 0;

    always #5 clock_in = ~clock_in;

    vgast_timing dut (.CLOCK_IN(clock_in), .RESETN_IN(resetn_in),
        .PIXEL_IN(vgast_rgb_t'(pix)), .PIXEL_REQ_OUT(req),
        .COLUMN_OUT(col), .ROW_OUT(row), .HSYNC_N_OUT(hs_n),
        .VSYNC_N_OUT(vs_n), .BLANKING_STROBE_N_OUT(blank_n),
        .RGB_OUT(rgb));

    vgast_monitor mon (.clk_in(clock_in), .hsync_n_in(hs_n),
        .vsync_n_in(vs_n), .blank_n_in(blank_n), .rgb_in(rgb),
        .hs_low_out(hs_low), .hs_period_out(hs_per),
        .vs_low_out(vs_low), .rgb_err_out(rgb_err));

    // new colour every clock so a stale or skipped pixel shows up
    always @(posedge clock_in) begin
        last_pix <= pix;
        cycles <= cycles + 1;
        #1 pix <= pix + 30'h0040_1003;
        if (cycles == 40000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic step();
        @(posedge clock_in);
        #1;
    endtask : step

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    // clocks spent while hsync (sel 0) or request (sel 1) stays at lvl
    task automatic hold(input bit sel, input logic lvl, output int k);
        k = 0;
        while ((sel ? req : hs_n) === lvl && k < 40000) begin
            step();
            k++;
        end
    endtask : hold

    task automatic t_sync();
        hold(0, 1'b0, n);
        cmp(n, 96);
        hold(0, 1'b1, n);
        cmp(n, 704);
        step();
        cmp(hs_per, 800);
    endtask : t_sync

    task automatic t_line();
        hold(1, 1'b0, n);
        cmp(n, 27343);
        cmp(vs_low, 1600);
        cmp(row, 0);
        for (int i = 0; i < 640; i++) begin
            cmp({req, blank_n}, 2'b11);
            cmp(col, i);
            cmp(rgb, last_pix);
            step();
        end
        cmp(rgb, 0);
        hold(0, 1'b1, n);
        cmp(n, 16);
        hold(0, 1'b0, n);
        cmp(hs_low, 96);
        hold(1, 1'b0, n);
        cmp(n, 48);
        cmp(row, 1);
        cmp(rgb_err, 0);
    endtask : t_line

    task automatic stop_test();
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    initial begin
        repeat (10) step();
        resetn_in = 1'b1;
        step();
        t_sync();
        t_line();
        stop_test();
    end
endmodule : tb_top
